// file: rtop_buf_access.sv
// Write merge and read view of the two output buffer nibbles
`timescale 1ns/1ps
`default_nettype none
module rtop_buf_access
(
  input  wire logic       wr_low,
  input  wire logic       wr_high,
  input  wire logic       byte_mode,
  input  wire logic [7:0] wdata,
  input  wire logic [3:0] buf_high,
  input  wire logic [3:0] buf_low,
  input  wire logic [7:0] func_sel,
  output logic      [3:0] buf_high_next,
  output logic      [3:0] buf_low_next,
  output logic      [7:0] read_view
);

  // Nibble update on a buffer write
  always_comb
  begin
    buf_high_next = buf_high;
    buf_low_next  = buf_low;
    if (byte_mode && (wr_low || wr_high))
    begin
      buf_high_next = wdata[7:4];
      buf_low_next  = wdata[3:0];
    end
    else
    begin
      if (wr_high)
        buf_high_next = wdata[7:4];
      if (wr_low)
        buf_low_next  = wdata[3:0];
    end
  end

  // Both addresses read the same view; port-mode bits read zero
  always_comb
  begin
    read_view = {buf_high, buf_low} & func_sel;
  end

endmodule
`default_nettype wire

// file: rtop_load_model.sv
// External load model on the real-time output pins
`timescale 1ns/1ps
`default_nettype none
module rtop_load_model
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] drive_lvl,
  output logic      [7:0] pin_lvl
);
  // Driven pins show the latch, released pins the load level
  assign pin_lvl = (pin_out & pin_oe) | (drive_lvl & ~pin_oe);
endmodule
`default_nettype wire

// file: rtop_pkg.sv
// Shared constants and types for the real-time output port
package rtop_pkg;

  // Data width of the register port and of the pin group
  localparam int DATA_W = 8;
  localparam int NIB_W  = 4;

  // Register selects on the special-function register port
  localparam logic [2:0] SEL_BUF_LOW   = 3'h0;
  localparam logic [2:0] SEL_BUF_HIGH  = 3'h1;
  localparam logic [2:0] SEL_PORT      = 3'h2;
  localparam logic [2:0] SEL_PIN_DIR   = 3'h3;
  localparam logic [2:0] SEL_FUNC_SEL  = 3'h4;
  localparam logic [2:0] SEL_TRIG_CTRL = 3'h5;

  // Reset values
  localparam logic [7:0] RST_BUF       = 8'h00;
  localparam logic [7:0] RST_LATCH     = 8'h00;
  localparam logic [7:0] RST_PIN_DIR   = 8'hFF;
  localparam logic [7:0] RST_FUNC_SEL  = 8'h00;
  localparam logic [7:0] RST_TRIG_CTRL = 8'h00;

  // Field positions of trigger_mode_control
  localparam int TCTRL_EXTERNAL_TRIGGER_SELECT_BIT = 0;
  localparam int TCTRL_BYTE_BIT = 1;
  localparam logic [7:0] TCTRL_MASK = 8'h03;

  // One register access from the processor side
  typedef struct packed {
    logic [2:0] sel;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rtop_sfr_req_t;

  // Trigger pulses from the timers and the external interrupt
  typedef struct packed {
    logic timer1_match_trigger;
    logic timer2_match_trigger;
    logic external_pin_trigger;
  } rtop_trig_t;

  // Per-nibble transfer strobes
  typedef struct packed {
    logic load_high;
    logic load_low;
  } rtop_load_t;

endpackage

// file: rtop_port.sv
// Real-time output port: buffers, control registers and pin latch
`timescale 1ns/1ps
`default_nettype none
module rtop_port
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Register port from the processor
  input  wire rtop_pkg::rtop_sfr_req_t sfr_req,
  output logic                  [7:0] sfr_rdata,
  output logic                        sfr_rvalid,
  // Trigger pulses, one cycle each, on clk_sys
  input  wire rtop_pkg::rtop_trig_t    trig,
  // Port pins, three signals per two-way pin
  input  wire logic             [7:0] port_pin_in,
  output logic                  [7:0] port_pin_out,
  output logic                  [7:0] port_pin_oe
);

  // Register state
  logic [3:0] buf_high_reg;
  logic [3:0] buf_high_next;
  logic [3:0] buf_low_reg;
  logic [3:0] buf_low_next;
  logic [7:0] latch_reg;
  logic [7:0] latch_next;
  logic [7:0] pin_dir_reg;
  logic [7:0] pin_dir_next;
  logic [7:0] func_sel_reg;
  logic [7:0] func_sel_next;
  logic [7:0] trig_ctrl_reg;
  logic [7:0] trig_ctrl_next;
  logic [7:0] oe_reg;
  logic [7:0] oe_next;

  // Read path state
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;

  // Pin input synchroniser
  logic [7:0] pin_sync1_reg;
  logic [7:0] pin_sync2_reg;

  // Decoded strobes and helper nets
  logic       wr_low;
  logic       wr_high;
  logic       byte_mode;
  logic       external_trigger_select;
  logic       load_high;
  logic       load_low;
  logic [3:0] buf_high_wr;
  logic [3:0] buf_low_wr;
  logic [7:0] buf_view;
  logic [7:0] rt_mask;
  logic [7:0] load_mask;
  logic [7:0] port_view;

  // Write strobe for one register select
  function automatic logic sel_write
  (
    input rtop_pkg::rtop_sfr_req_t req,
    input logic [2:0]              sel
  );
    sel_write = req.wr && (req.sel == sel);
  endfunction

  // Control field decode
  assign byte_mode =
    trig_ctrl_reg[rtop_pkg::TCTRL_BYTE_BIT];
  assign external_trigger_select =
    trig_ctrl_reg[rtop_pkg::TCTRL_EXTERNAL_TRIGGER_SELECT_BIT];
  assign wr_low  = sel_write(sfr_req, rtop_pkg::SEL_BUF_LOW);
  assign wr_high = sel_write(sfr_req, rtop_pkg::SEL_BUF_HIGH);

  // Trigger source selection; pulses already run on clk_sys,
  // so they reach the decode with no synchroniser in the way
  rtop_trig_decode u_trig_decode
  (
    .byte_mode               (byte_mode),
    .external_trigger_select (external_trigger_select),
    .trig                    (trig),
    .load_high               (load_high),
    .load_low                (load_low)
  );

  // Buffer write merge and read view; the view masks port-mode
  // bits, and both buffer selects read back the same byte
  rtop_buf_access u_buf_access
  (
    .wr_low        (wr_low),
    .wr_high       (wr_high),
    .byte_mode     (byte_mode),
    .wdata         (sfr_req.wdata),
    .buf_high      (buf_high_reg),
    .buf_low       (buf_low_reg),
    .func_sel      (func_sel_reg),
    .buf_high_next (buf_high_wr),
    .buf_low_next  (buf_low_wr),
    .read_view     (buf_view)
  );

  // Real-time bits and the bits a trigger touches this cycle;
  // port-mode bits never appear in the trigger mask
  always_comb
  begin
    rt_mask   = func_sel_reg;
    load_mask = {{4{load_high}}, {4{load_low}}} & rt_mask;
  end

  // Port read: input pins show the pin level, output pins the latch;
  // input pins read zero for two edges after reset
  always_comb
  begin
    port_view = (pin_dir_reg & pin_sync2_reg) | (~pin_dir_reg & latch_reg);
  end

  // Buffer nibbles take the merged write data
  always_comb
  begin
    buf_high_next = buf_high_wr;
    buf_low_next  = buf_low_wr;
  end

  // Buffer flip-flops
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      buf_high_reg <= rtop_pkg::RST_BUF[7:4];
      buf_low_reg  <= rtop_pkg::RST_BUF[3:0];
    end
    else
    begin
      buf_high_reg <= buf_high_next;
      buf_low_reg  <= buf_low_next;
    end
  end

  // Output latch next value; port writes reach only port-mode bits
  always_comb
  begin
    latch_next = latch_reg;
    if (sel_write(sfr_req, rtop_pkg::SEL_PORT))
    begin
      latch_next = (latch_reg & rt_mask)
                 | (sfr_req.wdata & ~rt_mask);
    end
    // Trigger copies the buffer as held before a same-cycle write
    latch_next = (latch_next & ~load_mask)
               | ({buf_high_reg, buf_low_reg} & load_mask);
  end

  // Output latch flip-flops
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      latch_reg <= rtop_pkg::RST_LATCH;
    end
    else
    begin
      latch_reg <= latch_next;
    end
  end

  // Control register next values
  always_comb
  begin
    pin_dir_next   = pin_dir_reg;
    func_sel_next  = func_sel_reg;
    trig_ctrl_next = trig_ctrl_reg;
    if (sel_write(sfr_req, rtop_pkg::SEL_PIN_DIR))
    begin
      pin_dir_next = sfr_req.wdata;
    end
    // Function select change leaves the latch as it is
    if (sel_write(sfr_req, rtop_pkg::SEL_FUNC_SEL))
    begin
      func_sel_next = sfr_req.wdata;
    end
    // Unused control bits are dropped and read back as zero
    if (sel_write(sfr_req, rtop_pkg::SEL_TRIG_CTRL))
    begin
      trig_ctrl_next = sfr_req.wdata & rtop_pkg::TCTRL_MASK;
    end
  end

  // Control register flip-flops
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_dir_reg   <= rtop_pkg::RST_PIN_DIR;
      func_sel_reg  <= rtop_pkg::RST_FUNC_SEL;
      trig_ctrl_reg <= rtop_pkg::RST_TRIG_CTRL;
    end
    else
    begin
      pin_dir_reg   <= pin_dir_next;
      func_sel_reg  <= func_sel_next;
      trig_ctrl_reg <= trig_ctrl_next;
    end
  end

  // Enable follows the direction register, zero means drive
  always_comb
  begin
    oe_next = ~pin_dir_next;
  end

  // Output enable flip-flops, all pins released in reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      oe_reg <= ~rtop_pkg::RST_PIN_DIR;
    end
    else
    begin
      oe_reg <= oe_next;
    end
  end

  // Two-stage synchroniser on the pin inputs; only the second
  // stage is read, so port reads lag the pins by two edges
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_sync1_reg <= 8'h00;
      pin_sync2_reg <= 8'h00;
    end
    else
    begin
      pin_sync1_reg <= port_pin_in;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // Read data mux, answered one cycle after the read strobe;
  // a write in the same cycle shows only on a later read
  always_comb
  begin
    rvalid_next = sfr_req.rd;
    rdata_next  = 8'h00;
    if (sfr_req.rd)
    begin
      unique case (sfr_req.sel)
        rtop_pkg::SEL_BUF_LOW:   rdata_next = buf_view;
        rtop_pkg::SEL_BUF_HIGH:  rdata_next = buf_view;
        rtop_pkg::SEL_PORT:      rdata_next = port_view;
        rtop_pkg::SEL_PIN_DIR:   rdata_next = pin_dir_reg;
        rtop_pkg::SEL_FUNC_SEL:  rdata_next = func_sel_reg;
        rtop_pkg::SEL_TRIG_CTRL: rdata_next = trig_ctrl_reg;
        default:                 rdata_next = 8'h00; // Unused select
      endcase
    end
  end

  // Read path flip-flops
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata    = rdata_reg;
  assign sfr_rvalid   = rvalid_reg;
  assign port_pin_out = latch_reg;
  assign port_pin_oe  = oe_reg;

endmodule
`default_nettype wire

// file: rtop_port_chk.sv
// Property checker for the real-time output port
`timescale 1ns/1ps
`default_nettype none
module rtop_port_chk
(
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire rtop_pkg::rtop_sfr_req_t sfr_req,
  input wire logic              [7:0] sfr_rdata,
  input wire logic                    sfr_rvalid,
  input wire rtop_pkg::rtop_trig_t    trig,
  input wire logic              [7:0] port_pin_in,
  input wire logic              [7:0] port_pin_out,
  input wire logic              [7:0] port_pin_oe
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [7:0] fs_reg;
  logic [1:0] ctl_reg;
  logic       hi_go;
  logic       lo_go;
  logic       pw;
  // Shadow copies of function select and trigger control
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fs_reg  <= 8'h00;
      ctl_reg <= 2'h0;
    end
    else if (sfr_req.wr && sfr_req.sel == rtop_pkg::SEL_FUNC_SEL)
      fs_reg  <= sfr_req.wdata;
    else if (sfr_req.wr && sfr_req.sel == rtop_pkg::SEL_TRIG_CTRL)
      ctl_reg <= sfr_req.wdata[1:0];
  end
  // Nibbles the present trigger may move
  assign lo_go = ctl_reg[0] ? trig.external_pin_trigger
                            : trig.timer1_match_trigger;
  assign hi_go = ctl_reg[1] ? lo_go
               : ctl_reg[0] ? trig.timer1_match_trigger
                            : trig.timer2_match_trigger;
  assign pw    = sfr_req.wr && sfr_req.sel == rtop_pkg::SEL_PORT;
  // Access steps
  sequence s_buf_read;
    sfr_req.rd && sfr_req.sel[2:1] == 2'h0;
  endsequence
  sequence s_dir_write;
    sfr_req.wr && sfr_req.sel == rtop_pkg::SEL_PIN_DIR;
  endsequence
  a_read_answer: assert property (sfr_req.rd |=> sfr_rvalid)
    else $error("read not answered");
  a_idle_quiet: assert property (!sfr_req.rd |=>
    !sfr_rvalid && sfr_rdata == 8'h00)
    else $error("read data without read");
  a_port_zero: assert property (s_buf_read |=>
    (sfr_rdata & ~$past(fs_reg)) == 8'h00)
    else $error("port-mode buffer bit not zero");
  a_ctl_read: assert property (
    sfr_req.rd && sfr_req.sel == rtop_pkg::SEL_TRIG_CTRL
    |=> sfr_rdata == {6'h00, $past(ctl_reg)})
    else $error("control read wrong");
  a_reset_dir: assert property ($fell(rst) |->
    port_pin_oe == 8'h00 && port_pin_out == 8'h00)
    else $error("pins not inputs after reset");
  a_dir_output: assert property (s_dir_write |=>
    port_pin_oe == ~$past(sfr_req.wdata))
    else $error("enable not from direction");
  a_high_hold: assert property (!hi_go |=>
    ((port_pin_out ^ $past(port_pin_out)) & $past(fs_reg) & 8'hF0) == 8'h00)
    else $error("high nibble moved");
  a_low_hold: assert property (!lo_go |=>
    ((port_pin_out ^ $past(port_pin_out)) & $past(fs_reg) & 8'h0F) == 8'h00)
    else $error("low nibble moved");
  a_port_hold: assert property (!pw |=>
    ((port_pin_out ^ $past(port_pin_out)) & ~$past(fs_reg)) == 8'h00)
    else $error("port-mode bit moved");
  a_port_write: assert property (pw |=>
    ((port_pin_out ^ $past(sfr_req.wdata)) & ~$past(fs_reg)) == 8'h00)
    else $error("port write wrong");
endmodule
bind rtop_port rtop_port_chk chk_u
(
  .clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .trig(trig),
  .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
  .port_pin_oe(port_pin_oe)
);
`default_nettype wire

// file: rtop_trig_decode.sv
// Trigger source selection for the two buffer nibbles
`timescale 1ns/1ps
`default_nettype none
module rtop_trig_decode
(
  input  wire logic              byte_mode,
  input  wire logic              external_trigger_select,
  input  wire rtop_pkg::rtop_trig_t trig,
  output logic                   load_high,
  output logic                   load_low
);

  // Pick the trigger for each nibble from mode and source bits
  always_comb
  begin
    load_high = 1'b0;
    load_low  = 1'b0;
    if (byte_mode)
    begin
      // Whole byte moves on one trigger
      load_high = external_trigger_select
                ? trig.external_pin_trigger
                : trig.timer1_match_trigger;
      load_low  = load_high;
    end
    else if (external_trigger_select)
    begin
      load_high = trig.timer1_match_trigger;
      load_low  = trig.external_pin_trigger;
    end
    else
    begin
      load_high = trig.timer2_match_trigger;
      load_low  = trig.timer1_match_trigger;
    end
  end

endmodule
`default_nettype wire

// file: test_realtime_output_port.sv
// Self-checking bench for the real-time output port
`timescale 1ns/1ps
`default_nettype none
module test_realtime_output_port;
  logic                    clk_sys;
  logic                    rst;
  rtop_pkg::rtop_sfr_req_t req;
  rtop_pkg::rtop_trig_t    trg;
  logic              [7:0] rdata;
  logic                    rvalid;
  logic              [7:0] pin_lvl;
  logic              [7:0] pin_out;
  logic              [7:0] pin_oe;
  logic              [7:0] cur;
  logic              [7:0] v;
  int                      err_total;
  int                      checks_done;
  int                      cyc = 0;
  rtop_port dut_u
  (
    .clk_sys(clk_sys), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
    .sfr_rvalid(rvalid), .trig(trg), .port_pin_in(pin_lvl),
    .port_pin_out(pin_out), .port_pin_oe(pin_oe)
  );
  rtop_load_model load_u
  (
    .pin_out(pin_out), .pin_oe(pin_oe), .drive_lvl(8'h9A),
    .pin_lvl(pin_lvl)
  );
  // Free-running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    req.sel = s;
    req.wdata = d;
    req.wr = 1'b1;
    tick();
    req.wr = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    req.sel = s;
    req.rd = 1'b1;
    tick();
    req.rd = 1'b0;
    chk(rdata, e);
    chk({7'h00, rvalid}, 8'h01);
    tick();
  endtask
  // Expected latch after trigger k (0 timer1, 1 timer2, 2 external)
  function automatic logic [7:0] nxt(input logic [7:0] c,
    input logic [7:0] b, input logic [1:0] m, input int k);
    logic lo;
    logic hi;
    lo = (k == (m[0] ? 2 : 0));
    hi = m[1] ? lo : (k == (m[0] ? 0 : 1));
    return {hi ? b[7:4] : c[7:4], lo ? b[3:0] : c[3:0]};
  endfunction
  // Main sequence
  initial
  begin
    req = '0;
    trg = '0;
    rst = 1'b1;
    err_total = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk(pin_oe, 8'h00);
    rd(rtop_pkg::SEL_PIN_DIR, 8'hFF);
    rd(rtop_pkg::SEL_FUNC_SEL, 8'h00);
    rd(rtop_pkg::SEL_TRIG_CTRL, 8'h00);
    wr(rtop_pkg::SEL_PORT, 8'hA5);
    wr(rtop_pkg::SEL_PIN_DIR, 8'h00);
    chk(pin_oe, 8'hFF);
    rd(rtop_pkg::SEL_PORT, 8'hA5);
    wr(rtop_pkg::SEL_BUF_LOW, 8'h3C);
    wr(rtop_pkg::SEL_BUF_HIGH, 8'h7E);
    rd(rtop_pkg::SEL_BUF_LOW, 8'h00);
    wr(rtop_pkg::SEL_FUNC_SEL, 8'h0F);
    rd(rtop_pkg::SEL_BUF_HIGH, 8'h0C);
    wr(rtop_pkg::SEL_PORT, 8'h5A);
    chk(pin_out, 8'h55);
    wr(rtop_pkg::SEL_FUNC_SEL, 8'hFF);
    rd(rtop_pkg::SEL_BUF_LOW, 8'h7C);
    wr(rtop_pkg::SEL_TRIG_CTRL, 8'hFF);
    rd(rtop_pkg::SEL_TRIG_CTRL, 8'h03);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    cur = 8'h55;
    // Every mode against every trigger source
    for (int m = 0; m < 4; m++)
    begin
      wr(rtop_pkg::SEL_TRIG_CTRL, 8'(m));
      for (int k = 0; k < 3; k++)
      begin
        v = 8'(29 * (m * 3 + k) + 17);
        wr(3'(k & 1), v);
        if (m < 2)
          wr(3'(~k & 1), v);
        trg = rtop_pkg::rtop_trig_t'(3'h4 >> k);
        tick();
        trg = '0;
        cur = nxt(cur, v, 2'(m), k);
        chk(pin_out, cur);
        tick();
      end
    end
    wr(rtop_pkg::SEL_PIN_DIR, 8'hF0);
    tick();
    tick();
    rd(rtop_pkg::SEL_PORT, {4'h9, cur[3:0]});
    report_and_stop();
  end
endmodule
`default_nettype wire
